// [dv/sscc_strap.sv]
// board strapping and loop lock detector at the block's pins
// assumes the bench picks the strap levels and whether pins float
`default_nettype none
module sscc_strap
  import sscc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic open_in,
  input wire logic [FB_W+6:0] strap_in,
  input wire logic [FB_W+6:0] div_in,
  output logic [FB_W+6:0] pins_out,
  output logic lock_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] stable_r; // cycles since the last divider change
  logic [FB_W+6:0] last_r; // divider setting seen one cycle ago
  ////////////////////////////////////////////////////////////////////
  // open pins pulled
  // pull resistors give the default strap when nothing drives the pins
  assign pins_out = open_in ?
    {FB_DEFAULT, POST_DEFAULT, POST_DEFAULT, PRE_DEFAULT} : strap_in;
  // loop relocks only after the setting has been quiet for four cycles
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stable_r <= 3'h0;
      last_r <= '0;
    end else begin
      last_r <= div_in;
      if (div_in != last_r) begin
        stable_r <= 3'h0;
      end else if (stable_r != 3'h4) begin
        stable_r <= stable_r + 3'h1;
      end
    end
  end
  assign lock_out = (stable_r == 3'h4);
endmodule
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the synthesizer startup control block
// assumes a 50 MHz clock and a shortened lock count of 8
`default_nettype none
module tb
  import sscc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_low = 1'b0; // high selects serial mode
  logic open = 1'b0; // pins left floating
  logic ref_sel = 1'b1;
  logic skip = 1'b0;
  logic level = 1'b0;
  logic swr = 1'b0; // serial commit pulse
  logic [FB_W+6:0] strap = '0;
  logic [FB_W+6:0] sval = '0; // serial divider values
  logic [FB_W+6:0] pins;
  logic [FB_W+6:0] div;
  logic lock, crystal_oscillator, byp, lvl, locked;
  int fails = 0;
  int check_count = 0;
  localparam logic [FB_W+6:0] DEF =
    {FB_DEFAULT, POST_DEFAULT, POST_DEFAULT, PRE_DEFAULT};
  always #10 clk = ~clk;
  sscc_strap board (.clk_in(clk), .rst_n_in(rst_n), .open_in(open),
    .strap_in(strap), .div_in(div), .pins_out(pins), .lock_out(lock));
  sscc_top #(.LOCK_COUNT(8)) uut (.CLK_IN(clk), .RST_N_IN(rst_n),
    .CE_IN(1'b1), .PARALLEL_MODE_SELECT_LOW_IN(sel_low),
    .FEEDBACK_DIVIDER_IN(pins[16:7]), .POST_DIVIDER_A_IN(pins[6:4]),
    .POST_DIVIDER_B_IN(pins[3:1]), .PRE_DIVIDER_IN(pins[0]),
    .REF_SELECT_IN(ref_sel), .LOOP_SKIP_TEST_LOW_IN(skip),
    .OUTPUT_LEVEL_CHOICE_IN(level), .SERIAL_WRITE_IN(swr),
    .SERIAL_FEEDBACK_IN(sval[16:7]), .SERIAL_POST_A_IN(sval[6:4]),
    .SERIAL_POST_B_IN(sval[3:1]), .SERIAL_PRE_IN(sval[0]),
    .LOOP_LOCK_IN(lock), .FEEDBACK_DIVIDER_OUT(div[16:7]),
    .POST_DIVIDER_A_OUT(div[6:4]), .POST_DIVIDER_B_OUT(div[3:1]),
    .PRE_DIVIDER_OUT(div[0]), .REF_CRYSTAL_OUT(crystal_oscillator),
    .LOOP_BYPASS_OUT(byp), .OUTPUT_LEVEL_HIGH_OUT(lvl),
    .LOOP_LOCKED_FLAG_OUT(locked));
  ////////////////////////////////////////////////////////////////////
  // common helpers: one compare, clock stepping, the closing report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs always move 2 ns after the edge, away from sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic test_done;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one serial commit; pulse spans exactly one edge
  task automatic serial_write(input logic [FB_W+6:0] v);
    sval = v;
    swr = 1'b1;
    step(1);
    swr = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////
  // startup in serial mode: defaults in reset, capture, pins frozen
  task automatic t_serial_start;
    rst_n = 1'b0;
    sel_low = 1'b1;
    strap = 17'h1_2345;
    step(12);
    chk(div, DEF);
    chk({crystal_oscillator, byp, lvl, locked}, 4'b1000);
    rst_n = 1'b1;
    step(1);
    chk(crystal_oscillator, REF_CRYSTAL);
    step(5);
    chk(div, 17'h1_2345);
    strap = 17'h0_ABCD;
    step(5);
    chk(div, 17'h1_2345);
    serial_write(17'h1_5A5A);
    chk(div, 17'h1_5A5A);
  endtask
  // floating pins at startup, then parallel mode follows pins live
  task automatic t_parallel_live;
    rst_n = 1'b0;
    sel_low = 1'b0;
    open = 1'b1;
    step(12);
    rst_n = 1'b1;
    step(6);
    chk(div, DEF);
    open = 1'b0;
    strap = 17'h0_3C71;
    step(4);
    chk(div, 17'h0_3C71);
    serial_write(17'h1_0000);
    step(1);
    chk(div, 17'h0_3C71);
  endtask
  // every combination of reference, bypass and output style
  task automatic t_statics;
    for (int i = 0; i < 8; i++) begin
      {ref_sel, skip, level} = i[2:0];
      step(4);
      chk({crystal_oscillator, byp, lvl}, i);
    end
    skip = 1'b0;
  endtask
  // lock flag rises after settling and drops on a divider change
  task automatic t_lock;
    for (int n = 0; n < 60 && locked !== 1'b1; n++) step(1);
    chk(locked, LOCKED);
    strap = 17'h1_1111;
    step(5);
    chk(locked, UNLOCKED);
    for (int n = 0; n < 60 && locked !== 1'b1; n++) step(1);
    chk(locked, LOCKED);
  endtask
  ////////////////////////////////////////////////////////////////////
  // reset after power-up
  initial begin
    t_serial_start();
    t_parallel_live();
    t_statics();
    t_statics();
    t_lock();
    test_done();
  end
  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    #(20 * 2000);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire

// [logic/sscc_pkg.sv]
// package for the synthesizer startup and static control block
// assumes a single 50 MHz clock domain and no register bus
`default_nettype none
package sscc_pkg;
  // divider field widths
  localparam int unsigned FB_W = 10;
  localparam int unsigned POST_W = 3;
  // defaults taken when the divider pins float
  localparam logic [FB_W-1:0] FB_DEFAULT = 10'h271;
  localparam logic [POST_W-1:0] POST_DEFAULT = 3'h0;
  localparam logic PRE_DEFAULT = 1'b1;
  // reference choice, output style and lock levels
  localparam logic REF_EXTERNAL = 1'b0;
  localparam logic REF_CRYSTAL = 1'b1;
  localparam logic LEVEL_LOW_SWING = 1'b0;
  localparam logic LOCKED = 1'b1;
  localparam logic UNLOCKED = 1'b0;
  // settle time before lock is shown after a new setting
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned LOCK_TIME_US = 100;
  localparam int unsigned LOCK_CYCLES =
    (LOCK_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned SYNC_STAGES = 2;
  // startup sequencer states
  typedef enum logic [1:0] {
    SSCC_IDLE = 2'b00,
    SSCC_CAPTURE = 2'b01,
    SSCC_SETTLE = 2'b10,
    SSCC_RUN = 2'b11
  } sscc_state_t;
endpackage
`default_nettype wire

// [logic/sscc_sync.sv]
// two flip-flop synchroniser for a bus of pin levels
// assumes the pins change slowly compared to the clock
`default_nettype none
module sscc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r; // first stage, read only by q_out

  // two stages; reset to the idle level so no false level leaks out
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= RST_VAL;
      q_out <= RST_VAL;
    end else if (ce_in) begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [logic/sscc_top.sv]
// startup and static control of a programmable clock synthesizer
// assumes pins are asynchronous and are synchronised here
// What this block and the other party do
// R1: capture dividers from pins at reset release
// R2: startup capture ignores parallel mode select
// R3: lock flag high when locked, else low
// R4: parallel mode: dividers follow pins live
// R5: reference select: 0 external, 1 crystal
// R6: bypass skips loop, post-dividers only
// R7: other party holds bypass low normally
// R8: reset low holds device, loads defaults
// R9: level select high swing, low default
// R10: floating pins give default divider settings
// R11: other party resets after power-up
// R12: parallel-only: select low, serial unused
// R13: serial mode freezes pins, serial may write
// R14: lock low from reset until relock
// R15: pins synchronised before updating dividers
`default_nettype none
module sscc_top
  import sscc_pkg::*;
#(
  parameter int unsigned FB_WIDTH = FB_W,
  parameter int unsigned LOCK_COUNT = LOCK_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic PARALLEL_MODE_SELECT_LOW_IN,
  input wire logic [FB_WIDTH-1:0] FEEDBACK_DIVIDER_IN,
  input wire logic [POST_W-1:0] POST_DIVIDER_A_IN,
  input wire logic [POST_W-1:0] POST_DIVIDER_B_IN,
  input wire logic PRE_DIVIDER_IN,
  input wire logic REF_SELECT_IN,
  input wire logic LOOP_SKIP_TEST_LOW_IN,
  input wire logic OUTPUT_LEVEL_CHOICE_IN,
  input wire logic SERIAL_WRITE_IN,
  input wire logic [FB_WIDTH-1:0] SERIAL_FEEDBACK_IN,
  input wire logic [POST_W-1:0] SERIAL_POST_A_IN,
  input wire logic [POST_W-1:0] SERIAL_POST_B_IN,
  input wire logic SERIAL_PRE_IN,
  input wire logic LOOP_LOCK_IN,
  output logic [FB_WIDTH-1:0] FEEDBACK_DIVIDER_OUT,
  output logic [POST_W-1:0] POST_DIVIDER_A_OUT,
  output logic [POST_W-1:0] POST_DIVIDER_B_OUT,
  output logic PRE_DIVIDER_OUT,
  output logic REF_CRYSTAL_OUT,
  output logic LOOP_BYPASS_OUT,
  output logic OUTPUT_LEVEL_HIGH_OUT,
  output logic LOOP_LOCKED_FLAG_OUT
);
  localparam int unsigned PIN_W = FB_WIDTH + 2 * POST_W + 5;
  localparam int unsigned CNT_W = $clog2(LOCK_COUNT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LOCK_COUNT - 1);
  // sync reset levels: crystal stays chosen while the stages fill
  localparam logic [PIN_W-1:0] PIN_RST = {FB_WIDTH'(FB_DEFAULT),
    POST_DEFAULT, POST_DEFAULT, PRE_DEFAULT, REF_CRYSTAL, 1'b0,
    LEVEL_LOW_SWING, 1'b0};

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [PIN_W-1:0] pin_raw; // every asynchronous pin level but the lock detector, packed
  logic [PIN_W-1:0] pin_sync; // same, after two flops
  logic [FB_WIDTH-1:0] fb_pin; // synced feedback divider pins
  logic [POST_W-1:0] pa_pin; // synced post divider a pins
  logic [POST_W-1:0] pb_pin; // synced post divider b pins
  logic pre_pin; // synced pre-divider pin
  logic ref_pin; // synced reference select
  logic skip_pin; // synced bypass level
  logic lev_pin; // synced output level choice
  logic par_low; // synced parallel mode select (low = parallel)
  logic lock_pin; // synced analog lock detector

  assign pin_raw = {FEEDBACK_DIVIDER_IN, POST_DIVIDER_A_IN,
                    POST_DIVIDER_B_IN, PRE_DIVIDER_IN, REF_SELECT_IN,
                    LOOP_SKIP_TEST_LOW_IN, OUTPUT_LEVEL_CHOICE_IN,
                    PARALLEL_MODE_SELECT_LOW_IN};

  // R15: sync all pins
  sscc_sync #(.WIDTH(PIN_W), .RST_VAL(PIN_RST)) u_pin_sync (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .d_in(pin_raw),
    .q_out(pin_sync)
  );

  // lock detector from the analog loop is also asynchronous
  sscc_sync #(.WIDTH(1), .RST_VAL(UNLOCKED)) u_lock_sync (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .d_in(LOOP_LOCK_IN),
    .q_out(lock_pin)
  );

  assign {fb_pin, pa_pin, pb_pin, pre_pin, ref_pin, skip_pin, lev_pin,
          par_low} = pin_sync;

  ////////////////////////////////////////////////////////////////////
  // startup sequencer
  sscc_state_t state_r; // current phase
  sscc_state_t state_nxt; // next phase
  logic [CNT_W-1:0] cnt_r; // settle counter
  logic cfg_change; // divider setting about to change

  // capture waits two cycles so the sync stages hold real pin levels
  logic [1:0] warm_r; // cycles since reset release

  // R8: defaults while reset low
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      warm_r <= 2'h0;
    end else if (CE_IN && warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end

  // next state logic
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SSCC_IDLE: begin
        if (warm_r == 2'h2) begin
          state_nxt = SSCC_CAPTURE;
        end
      end
      SSCC_CAPTURE: begin
        state_nxt = SSCC_SETTLE;
      end
      SSCC_SETTLE: begin
        if (cnt_r == CNT_LAST && lock_pin) begin
          state_nxt = SSCC_RUN;
        end
      end
      SSCC_RUN: begin
        if (cfg_change || !lock_pin) begin
          state_nxt = SSCC_SETTLE;
        end
      end
      default: begin
        state_nxt = SSCC_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= SSCC_IDLE;
    end else if (CE_IN) begin
      state_r <= state_nxt;
    end
  end

  // settle counter, restarts on every new setting
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnt_r <= '0;
    end else if (CE_IN) begin
      if (state_r != SSCC_SETTLE || cfg_change) begin
        cnt_r <= '0;
      end else if (cnt_r != CNT_LAST) begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // divider configuration
  logic take_pins; // load the dividers from the pins
  logic take_serial; // load the dividers from the serial side
  logic [FB_WIDTH-1:0] fb_src; // chosen source values
  logic [POST_W-1:0] pa_src;
  logic [POST_W-1:0] pb_src;
  logic pre_src;

  // R1: R2: capture ignores mode
  // R4: parallel follows pins
  // R13: serial mode freezes pins
  assign take_pins = (state_r == SSCC_CAPTURE) ||
                     (state_r != SSCC_IDLE && !par_low);
  assign take_serial = SERIAL_WRITE_IN && par_low &&
                       state_r != SSCC_IDLE && state_r != SSCC_CAPTURE;
  assign fb_src = take_pins ? fb_pin : SERIAL_FEEDBACK_IN;
  assign pa_src = take_pins ? pa_pin : SERIAL_POST_A_IN;
  assign pb_src = take_pins ? pb_pin : SERIAL_POST_B_IN;
  assign pre_src = take_pins ? pre_pin : SERIAL_PRE_IN;
  assign cfg_change = (take_pins || take_serial) &&
    ({fb_src, pa_src, pb_src, pre_src} !=
     {FEEDBACK_DIVIDER_OUT, POST_DIVIDER_A_OUT, POST_DIVIDER_B_OUT,
      PRE_DIVIDER_OUT});

  // R8: R10: default divider settings
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      FEEDBACK_DIVIDER_OUT <= FB_WIDTH'(FB_DEFAULT);
      POST_DIVIDER_A_OUT <= POST_DEFAULT;
      POST_DIVIDER_B_OUT <= POST_DEFAULT;
      PRE_DIVIDER_OUT <= PRE_DEFAULT;
    end else if (CE_IN && (take_pins || take_serial)) begin
      FEEDBACK_DIVIDER_OUT <= fb_src;
      POST_DIVIDER_A_OUT <= pa_src;
      POST_DIVIDER_B_OUT <= pb_src;
      PRE_DIVIDER_OUT <= pre_src;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // static controls
  // R5: R6: R9: route controls
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      REF_CRYSTAL_OUT <= REF_CRYSTAL;
      LOOP_BYPASS_OUT <= 1'b0;
      OUTPUT_LEVEL_HIGH_OUT <= LEVEL_LOW_SWING;
    end else if (CE_IN) begin
      REF_CRYSTAL_OUT <= (ref_pin == REF_CRYSTAL);
      LOOP_BYPASS_OUT <= skip_pin;
      OUTPUT_LEVEL_HIGH_OUT <= lev_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // lock flag
  // R3: R14: lock indication
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      LOOP_LOCKED_FLAG_OUT <= UNLOCKED;
    end else if (CE_IN) begin
      LOOP_LOCKED_FLAG_OUT <= (state_nxt == SSCC_RUN) ? LOCKED : UNLOCKED;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // assertions
  property p_lock_low_settle; // R14
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      (state_r == SSCC_SETTLE && CE_IN && cnt_r != CNT_LAST)
        |=> !LOOP_LOCKED_FLAG_OUT;
  endproperty
  a_lock_low_settle: assert property (p_lock_low_settle) // R14
    else $error("lock shown while settling");

  property p_lock_needs_loop; // R3
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      LOOP_LOCKED_FLAG_OUT |-> $past(lock_pin);
  endproperty
  a_lock_needs_loop: assert property (p_lock_needs_loop) // R3
    else $error("lock shown without loop lock");

  sequence s_capture;
    state_r == SSCC_CAPTURE && CE_IN;
  endsequence
  property p_capture; // R1
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      s_capture |=> FEEDBACK_DIVIDER_OUT == $past(fb_pin);
  endproperty
  a_capture: assert property (p_capture) // R1
    else $error("startup capture missed");

  property p_capture_any_mode; // R2
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && state_r == SSCC_CAPTURE && par_low)
        |=> PRE_DIVIDER_OUT == $past(pre_pin);
  endproperty
  a_capture_any_mode: assert property (p_capture_any_mode) // R2
    else $error("capture skipped in serial mode");

  property p_parallel_follow; // R4
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && !par_low && state_r != SSCC_IDLE)
        |=> POST_DIVIDER_A_OUT == $past(pa_pin);
  endproperty
  a_parallel_follow: assert property (p_parallel_follow) // R4
    else $error("parallel pins not followed");

  property p_serial_freeze; // R13
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && par_low && !SERIAL_WRITE_IN && state_r != SSCC_CAPTURE)
        |=> $stable(FEEDBACK_DIVIDER_OUT);
  endproperty
  a_serial_freeze: assert property (p_serial_freeze) // R13
    else $error("dividers moved in serial mode");

  property p_ref_route; // R5
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      CE_IN |=> REF_CRYSTAL_OUT == $past(ref_pin);
  endproperty
  a_ref_route: assert property (p_ref_route) // R5
    else $error("reference route wrong");

  property p_bypass_level; // R6
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      CE_IN ##1 CE_IN |=> LOOP_BYPASS_OUT == $past(skip_pin);
  endproperty
  a_bypass_level: assert property (p_bypass_level) // R6
    else $error("bypass level wrong");
endmodule
`default_nettype wire
